// File: fsu_pkg.sv
// package of constants for the fifo serial unit
package fsu_pkg;
    // mode register field positions
    localparam int MODE_CHR_BIT    = 6;
    localparam int MODE_PAR_BIT    = 5;
    localparam int MODE_STOP_BIT   = 3;
    localparam int MODE_ODD_BIT    = 4;
    // control register field positions
    localparam int CTRL_CKS_HI_BIT = 1;
    localparam int CTRL_CKS_LO_BIT = 0;
    // fifo geometry and oversampling
    localparam int FIFO_DEPTH      = 16;
    localparam int FIFO_CNT_W      = 5;
    localparam int OVERSAMPLE      = 16;
    localparam int SAMPLE_MID      = 7;
    // trigger levels, transmit side then receive side
    localparam logic [4:0] TX_TRIG_0 = 5'h08;
    localparam logic [4:0] TX_TRIG_1 = 5'h04;
    localparam logic [4:0] TX_TRIG_2 = 5'h02;
    localparam logic [4:0] TX_TRIG_3 = 5'h01;
    localparam logic [4:0] RX_TRIG_0 = 5'h01;
    localparam logic [4:0] RX_TRIG_1 = 5'h04;
    localparam logic [4:0] RX_TRIG_2 = 5'h08;
    localparam logic [4:0] RX_TRIG_3 = 5'h0E;
    // reset values
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [3:0] TICK_RST  = 4'h0;
    // tx end and tx low start set: nothing queued yet
    localparam logic [6:0] STATUS_RST = 7'h60;
endpackage

// File: fsu_fifo_if.sv
// interface between the unit top and its fifo
interface fsu_fifo_if #(parameter int W = 8, parameter int CW = 5);
    logic          push;
    logic [W-1:0]  wdata;
    logic          pop;
    logic [W-1:0]  rdata;
    logic          clear;
    logic [CW-1:0] count;
    modport owner (output push, output wdata, output pop, output clear,
                   input rdata, input count);
    modport store (input push, input wdata, input pop, input clear,
                   output rdata, output count);
endinterface

// File: fsu_fifo.sv
// sixteen entry byte fifo with count
module fsu_fifo
    import fsu_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int W     = 8
) (
    input  wire logic   i_clk,
    input  wire logic   i_rst,
    fsu_fifo_if.store   bus
);
    logic [W-1:0]      mem_q [DEPTH];
    logic [3:0]        wp_q, wp_d, rp_q, rp_d;
    logic [FIFO_CNT_W-1:0] cnt_q, cnt_d;
    logic              do_push, do_pop;

    // push ignored when full, pop ignored when empty
    always_comb begin
        do_push = bus.push && (cnt_q != FIFO_CNT_W'(DEPTH));
        do_pop  = bus.pop && (cnt_q != '0);
        wp_d    = wp_q + {3'h0, do_push};
        rp_d    = rp_q + {3'h0, do_pop};
        cnt_d   = cnt_q + FIFO_CNT_W'(do_push) - FIFO_CNT_W'(do_pop);
        if (bus.clear) begin
            wp_d  = '0;
            rp_d  = '0;
            cnt_d = '0;
        end
    end

    // pointer registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // storage has no reset, contents are only valid under the count
    always_ff @(posedge i_clk) begin
        if (do_push && !bus.clear) begin
            mem_q[wp_q] <= bus.wdata;
        end
    end

    assign bus.rdata = mem_q[rp_q];
    assign bus.count = cnt_q;
endmodule

// File: fsu_top.sv
// fifo serial unit: async transmitter and receiver with byte fifos
// Function
// - separate sixteen byte fifos for transmit and receive data
// - char length select zero gives eight data bits, one gives seven
// - stop select picks one or two stops; parity enable adds parity bit
// - format bits: char length bit 6, parity bit 5, stop bit 3
// - frame is start, data, optional parity, stops; at most twelve bits
// - clock select 00 internal, 01 internal driven out, 1x external pin
// - driven serial clock runs at sixteen times the bit rate
// - flag framing, parity, rx trigger, data ready, break, tx low level
// - report byte counts of transmit and receive fifos
// - tx enable off resets shifter; flags and fifos keep contents
// - tx enable off mid frame floats transmit data on the next clock
// - clock output starts when selected, regardless of enables
// - tx enable gives mark line; rx enable idles waiting for start
// - flags clear only on write of zero after being read as one
// - data bits sent and assembled least significant bit first
// - with modem control, clear to send high pauses after frame
// - tx low flag sets when tx count is below selected trigger
// - receiver checks first stop bit only
module fsu_top
    import fsu_pkg::*;
(
    input  wire logic       I_MCLK,
    input  wire logic       I_RST,
    input  wire logic [7:0] I_MODE,
    input  wire logic [7:0] I_CTRL_CKS,
    input  wire logic       I_TX_ENABLE,
    input  wire logic       I_RX_ENABLE,
    input  wire logic [7:0] I_DIVISOR,
    input  wire logic [1:0] I_TX_TRIG_SEL,
    input  wire logic [1:0] I_RX_TRIG_SEL,
    input  wire logic       I_MODEM_EN,
    input  wire logic       I_LOOPBACK,
    input  wire logic       I_TX_FIFO_CLEAR,
    input  wire logic       I_RX_FIFO_CLEAR,
    input  wire logic       I_TX_WR,
    input  wire logic [7:0] I_TX_DATA,
    input  wire logic       I_RX_RD,
    input  wire logic       I_STATUS_RD,
    input  wire logic       I_STATUS_WR,
    input  wire logic [6:0] I_STATUS_WDATA,
    input  wire logic       I_RXD,
    input  wire logic       I_CTS_N,
    input  wire logic       I_SCK,
    output logic            O_TXD,
    output logic            O_TXD_OE,
    output logic            O_SCK,
    output logic            O_SCK_OE,
    output logic            O_RTS_N,
    output logic [7:0]      O_RX_DATA,
    output logic [6:0]      O_STATUS,
    output logic [4:0]      O_TX_COUNT,
    output logic [4:0]      O_RX_COUNT
);
    // status bit order: 0 data ready, 1 rx trigger, 2 parity err, 3 framing
    // err, 4 break, 5 tx end, 6 tx low
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} fsu_tx_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} fsu_rx_e;

    fsu_fifo_if #(.W(8),  .CW(FIFO_CNT_W)) txf ();
    fsu_fifo_if #(.W(10), .CW(FIFO_CNT_W)) rxf ();

    fsu_fifo #(.DEPTH(FIFO_DEPTH), .W(8)) u_txf (
        .i_clk (I_MCLK),
        .i_rst (I_RST),
        .bus   (txf.store)
    );
    // receive store, data plus its two error bits
    fsu_fifo #(.DEPTH(FIFO_DEPTH), .W(10)) u_rxf (
        .i_clk (I_MCLK),
        .i_rst (I_RST),
        .bus   (rxf.store)
    );

    function automatic logic [4:0] trig_of(input logic [1:0] s, input logic tx);
        case (s)
            2'h0:    trig_of = tx ? TX_TRIG_0 : RX_TRIG_0;
            2'h1:    trig_of = tx ? TX_TRIG_1 : RX_TRIG_1;
            2'h2:    trig_of = tx ? TX_TRIG_2 : RX_TRIG_2;
            default: trig_of = tx ? TX_TRIG_3 : RX_TRIG_3;
        endcase
    endfunction

    // pin synchronisers, second stage is the only reader of the first
    logic [2:0] sck_s_q, rxd_s_q, cts_s_q;
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            sck_s_q <= '0;
            rxd_s_q <= 3'h7;
            cts_s_q <= '0;
        end else begin
            sck_s_q <= {sck_s_q[1:0], I_SCK};
            rxd_s_q <= {rxd_s_q[1:0], I_RXD};
            cts_s_q <= {cts_s_q[1:0], I_CTS_N};
        end
    end

    // baud generator: one internal tick per 2*(divisor+1) master clocks
    logic [7:0] div_q, div_d;
    logic       int_tick, sck_out_q, sck_out_d, ext_tick, tick;
    logic       ext_sel, out_sel;
    always_comb begin
        ext_sel   = I_CTRL_CKS[CTRL_CKS_HI_BIT];
        out_sel   = !ext_sel && I_CTRL_CKS[CTRL_CKS_LO_BIT];
        int_tick  = (div_q == I_DIVISOR);
        div_d     = int_tick ? DIV_RESET : div_q + 8'h01;
        // pin toggles on every int_tick, twice per tick period, so one full pin cycle per tick
        sck_out_d = int_tick ? !sck_out_q : sck_out_q;
        ext_tick  = sck_s_q[1] && !sck_s_q[2];
        // source choice, external edges assumed at sixteen per bit
        tick      = ext_sel ? ext_tick : (int_tick && sck_out_q);
    end
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            div_q     <= DIV_RESET;
            sck_out_q <= 1'b0;
        end else begin
            div_q     <= div_d;
            sck_out_q <= sck_out_d;
        end
    end

    // clock pin driven whenever output selected, enables ignored
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            O_SCK    <= 1'b0;
            O_SCK_OE <= 1'b0;
        end else begin
            O_SCK    <= sck_out_q;
            O_SCK_OE <= out_sel;
        end
    end

    // transmitter
    fsu_tx_e    tx_st_q, tx_st_d;
    logic [3:0] tx_tk_q, tx_tk_d;
    logic [2:0] tx_bit_q, tx_bit_d;
    logic [7:0] tx_sh_q, tx_sh_d;
    logic       tx_par_q, tx_par_d, tx_stp2_q, tx_stp2_d;
    logic       tx_line, tx_pop, tx_end_set, tx_bit_end;
    logic       cts_ok;
    always_comb begin
        tx_st_d    = tx_st_q;
        tx_tk_d    = tx_tk_q;
        tx_bit_d   = tx_bit_q;
        tx_sh_d    = tx_sh_q;
        tx_par_d   = tx_par_q;
        tx_stp2_d  = tx_stp2_q;
        tx_pop     = 1'b0;
        tx_end_set = 1'b0;
        tx_line    = 1'b1;
        tx_bit_end = tick && (tx_tk_q == 4'(OVERSAMPLE - 1));
        // clear to send only matters with modem control on
        cts_ok     = !I_MODEM_EN || !cts_s_q[2];
        if (tick) begin
            tx_tk_d = tx_tk_q + 4'h1;
        end
        // start, data, parity, stops in that order
        case (tx_st_q)
            TX_IDLE: begin
                tx_tk_d = TICK_RST;
                if (tick && txf.count != '0 && cts_ok) begin
                    tx_pop  = 1'b1;
                    tx_sh_d = txf.rdata;
                    tx_st_d = TX_START;
                end
            end
            TX_START: begin
                tx_line = 1'b0;
                if (tx_bit_end) begin
                    tx_st_d  = TX_DATA;
                    tx_bit_d = '0;
                    tx_par_d = I_MODE[MODE_ODD_BIT];
                    // seven bit frames clear the msb so parity skips it
                    if (I_MODE[MODE_CHR_BIT]) begin
                        tx_sh_d[7] = 1'b0;
                    end
                end
            end
            TX_DATA: begin
                tx_line = tx_sh_q[0];
                if (tx_bit_end) begin
                    tx_par_d = tx_par_q ^ tx_sh_q[0];
                    tx_sh_d  = {1'b0, tx_sh_q[7:1]};
                    tx_bit_d = tx_bit_q + 3'h1;
                    // data length from the mode byte
                    if (tx_bit_q == (I_MODE[MODE_CHR_BIT] ? 3'h6 : 3'h7)) begin
                        tx_st_d   = I_MODE[MODE_PAR_BIT] ? TX_PAR : TX_STOP;
                        tx_stp2_d = I_MODE[MODE_STOP_BIT];
                    end
                end
            end
            TX_PAR: begin
                tx_line = tx_par_q;
                if (tx_bit_end) begin
                    tx_st_d = TX_STOP;
                end
            end
            TX_STOP: begin
                if (tx_bit_end) begin
                    if (tx_stp2_q) begin
                        tx_stp2_d = 1'b0;
                    end else if (txf.count != '0 && cts_ok) begin
                        // back to back frame when data waits
                        tx_pop  = 1'b1;
                        tx_sh_d = txf.rdata;
                        tx_st_d = TX_START;
                    end else begin
                        tx_end_set = 1'b1;
                        tx_st_d    = TX_IDLE;
                    end
                end
            end
            default: tx_st_d = TX_IDLE;
        endcase
        if (!I_TX_ENABLE) begin
            tx_st_d  = TX_IDLE;
            tx_pop   = 1'b0;
            tx_tk_d  = TICK_RST;
        end
    end
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            tx_st_q   <= TX_IDLE;
            tx_tk_q   <= TICK_RST;
            tx_bit_q  <= '0;
            tx_sh_q   <= '0;
            tx_par_q  <= 1'b0;
            tx_stp2_q <= 1'b0;
            O_TXD     <= 1'b1;
            O_TXD_OE  <= 1'b0;
        end else begin
            tx_st_q   <= tx_st_d;
            tx_tk_q   <= tx_tk_d;
            tx_bit_q  <= tx_bit_d;
            tx_sh_q   <= tx_sh_d;
            tx_par_q  <= tx_par_d;
            tx_stp2_q <= tx_stp2_d;
            O_TXD     <= tx_line;
            // floats the cycle after enable drops
            O_TXD_OE  <= I_TX_ENABLE;
        end
    end
    assign txf.push  = I_TX_WR;
    assign txf.wdata = I_TX_DATA;
    assign txf.pop   = tx_pop;
    assign txf.clear = I_TX_FIFO_CLEAR;

    // receiver
    fsu_rx_e    rx_st_q, rx_st_d;
    logic [3:0] rx_tk_q, rx_tk_d;
    logic [2:0] rx_bit_q, rx_bit_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic       rx_par_q, rx_par_d, rx_perr_q, rx_perr_d;
    logic       rx_in, rx_samp, rx_push, rx_ferr, rx_brk, brk_held;
    always_comb begin
        rx_st_d   = rx_st_q;
        rx_tk_d   = tick ? rx_tk_q + 4'h1 : rx_tk_q;
        rx_bit_d  = rx_bit_q;
        rx_sh_d   = rx_sh_q;
        rx_par_d  = rx_par_q;
        rx_perr_d = rx_perr_q;
        rx_push   = 1'b0;
        rx_ferr   = 1'b0;
        rx_brk    = 1'b0;
        rx_in     = I_LOOPBACK ? tx_line : rxd_s_q[2];
        rx_samp   = tick && (rx_tk_q == 4'(SAMPLE_MID));
        case (rx_st_q)
            // idle waits for a falling line
            RX_IDLE: begin
                rx_tk_d = TICK_RST;
                if (tick && !rx_in) begin
                    rx_st_d = RX_START;
                    rx_tk_d = 4'h1;
                end
            end
            RX_START: begin
                // start must still be low at mid bit
                if (rx_samp) begin
                    rx_st_d   = rx_in ? RX_IDLE : RX_DATA;
                    rx_bit_d  = '0;
                    rx_sh_d   = '0;
                    rx_par_d  = I_MODE[MODE_ODD_BIT];
                    rx_perr_d = 1'b0;
                end
            end
            RX_DATA: begin
                if (rx_samp) begin
                    rx_par_d = rx_par_q ^ rx_in;
                    rx_bit_d = rx_bit_q + 3'h1;
                    // assemble lsb first, seven bit frames land low
                    if (I_MODE[MODE_CHR_BIT]) begin
                        rx_sh_d = {1'b0, rx_in, rx_sh_q[6:1]};
                    end else begin
                        rx_sh_d = {rx_in, rx_sh_q[7:1]};
                    end
                    if (rx_bit_q == (I_MODE[MODE_CHR_BIT] ? 3'h6 : 3'h7)) begin
                        rx_st_d = I_MODE[MODE_PAR_BIT] ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (rx_samp) begin
                    rx_perr_d = rx_par_q ^ rx_in;
                    rx_st_d   = RX_STOP;
                end
            end
            RX_STOP: begin
                // only the first stop is checked; a second is idle time
                if (rx_samp) begin
                    rx_ferr = !rx_in;
                    rx_brk  = !rx_in && (rx_sh_q == 8'h00);
                    rx_push = !brk_held;
                    rx_st_d = RX_IDLE;
                end
            end
            default: rx_st_d = RX_IDLE;
        endcase
        if (!I_RX_ENABLE) begin
            rx_st_d = RX_IDLE;
            rx_push = 1'b0;
            rx_ferr = 1'b0;
            rx_brk  = 1'b0;
        end
    end
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            rx_st_q   <= RX_IDLE;
            rx_tk_q   <= TICK_RST;
            rx_bit_q  <= '0;
            rx_sh_q   <= '0;
            rx_par_q  <= 1'b0;
            rx_perr_q <= 1'b0;
        end else begin
            rx_st_q   <= rx_st_d;
            rx_tk_q   <= rx_tk_d;
            rx_bit_q  <= rx_bit_d;
            rx_sh_q   <= rx_sh_d;
            rx_par_q  <= rx_par_d;
            rx_perr_q <= rx_perr_d;
        end
    end
    assign rxf.push  = rx_push;
    assign rxf.wdata = {rx_ferr, rx_perr_q, rx_sh_q};
    assign rxf.pop   = I_RX_RD;
    assign rxf.clear = I_RX_FIFO_CLEAR;

    // status flags
    logic [6:0] st_q, st_d, seen_q, seen_d, st_set;
    logic [4:0] tx_trig, rx_trig;
    always_comb begin
        tx_trig = trig_of(I_TX_TRIG_SEL, 1'b1);
        rx_trig = trig_of(I_RX_TRIG_SEL, 1'b0);
        // event sources; tx low below trigger
        st_set[0] = rx_push;
        st_set[1] = (rxf.count >= rx_trig);
        st_set[2] = rx_push && rx_perr_q;
        st_set[3] = rx_push && rx_ferr;
        st_set[4] = rx_brk;
        st_set[5] = tx_end_set;
        st_set[6] = (txf.count < tx_trig);
        // remember flags read as one, a zero write clears only those
        seen_d = I_STATUS_RD ? st_q : seen_q;
        st_d   = st_q;
        if (I_STATUS_WR) begin
            st_d   = st_q & (I_STATUS_WDATA | ~seen_q);
            seen_d = seen_q & I_STATUS_WDATA;
        end
        // set beats a clear in the same cycle
        st_d = st_d | st_set;
    end
    // flags and fifo counts ignore the enables
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            st_q       <= STATUS_RST;
            seen_q     <= '0;
            O_STATUS   <= STATUS_RST;
            O_TX_COUNT <= '0;
            O_RX_COUNT <= '0;
            O_RX_DATA  <= '0;
            O_RTS_N    <= 1'b0;
        end else begin
            st_q       <= st_d;
            seen_q     <= seen_d;
            O_STATUS   <= st_d;
            O_TX_COUNT <= txf.count;
            O_RX_COUNT <= rxf.count;
            O_RX_DATA  <= rxf.rdata[7:0];
            O_RTS_N    <= I_MODEM_EN && (rxf.count == 5'(FIFO_DEPTH));
        end
    end
    // break holds off storing until software clears its flag
    assign brk_held = st_q[4];
endmodule

// File: fsu_monitor.sv
// concurrent checks on the fifo serial unit top ports
module fsu_monitor
    import fsu_pkg::*;
(
    input  wire logic       I_MCLK,
    input  wire logic       I_RST,
    input  wire logic [7:0] I_CTRL_CKS,
    input  wire logic       I_TX_ENABLE,
    input  wire logic [1:0] I_TX_TRIG_SEL,
    input  wire logic       I_TX_FIFO_CLEAR,
    input  wire logic       I_RX_FIFO_CLEAR,
    input  wire logic       O_TXD,
    input  wire logic       O_TXD_OE,
    input  wire logic       O_SCK_OE,
    input  wire logic [6:0] O_STATUS,
    input  wire logic [4:0] O_TX_COUNT,
    input  wire logic [4:0] O_RX_COUNT
);
    logic [4:0] trig;
    // tx low threshold per selector, kept apart from the design tables
    assign trig = I_TX_TRIG_SEL == 2'h0 ? 5'h08 : I_TX_TRIG_SEL == 2'h1 ? 5'h04 :
                  I_TX_TRIG_SEL == 2'h2 ? 5'h02 : 5'h01;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    // a fifo clear lands on the count within two edges
    sequence tx_emptied;
        ##[1:2] O_TX_COUNT == 5'h00;
    endsequence
    sequence rx_emptied;
        ##[1:2] O_RX_COUNT == 5'h00;
    endsequence
    reset_status_a: assert property ($fell(I_RST) |-> O_STATUS == 7'h60)
        else $error("status wrong after reset");
    oe_enable_a: assert property (I_TX_ENABLE |=> O_TXD_OE)
        else $error("txd not driven while enabled");
    oe_float_a: assert property (!I_TX_ENABLE |=> !O_TXD_OE)
        else $error("txd still driven after disable");
    mark_idle_a: assert property ($rose(O_TXD_OE) |-> O_TXD)
        else $error("line not at mark on enable");
    sck_drive_a: assert property (I_CTRL_CKS[1:0] == 2'b01 |=> ##[0:1] O_SCK_OE)
        else $error("clock output not driven");
    sck_quiet_a: assert property (I_CTRL_CKS[1:0] != 2'b01 |=> ##[0:1] !O_SCK_OE)
        else $error("clock pin driven when not selected");
    tx_bound_a: assert property (O_TX_COUNT <= 5'h10)
        else $error("tx count above depth");
    rx_bound_a: assert property (O_RX_COUNT <= 5'h10)
        else $error("rx count above depth");
    tx_low_a: assert property ((O_TX_COUNT < trig) && $stable(O_TX_COUNT) &&
        $stable(I_TX_TRIG_SEL) |-> ##[0:1] O_STATUS[6])
        else $error("tx low flag missing");
    tx_clear_a: assert property (I_TX_FIFO_CLEAR |-> tx_emptied)
        else $error("tx fifo not emptied");
    rx_clear_a: assert property (I_RX_FIFO_CLEAR |-> rx_emptied)
        else $error("rx fifo not emptied");
endmodule
bind fsu_top fsu_monitor fsu_monitor_inst (.I_MCLK(I_MCLK), .I_RST(I_RST),
    .I_CTRL_CKS(I_CTRL_CKS), .I_TX_ENABLE(I_TX_ENABLE), .I_TX_TRIG_SEL(I_TX_TRIG_SEL),
    .I_TX_FIFO_CLEAR(I_TX_FIFO_CLEAR), .I_RX_FIFO_CLEAR(I_RX_FIFO_CLEAR), .O_TXD(O_TXD),
    .O_TXD_OE(O_TXD_OE), .O_SCK_OE(O_SCK_OE), .O_STATUS(O_STATUS),
    .O_TX_COUNT(O_TX_COUNT), .O_RX_COUNT(O_RX_COUNT));

// File: fsu_remote_model.sv
// remote serial device: decodes the transmit line and sends frames back
module fsu_remote_model (
    input  wire logic       i_line,
    input  wire logic [7:0] i_mode,
    output logic            o_rxd,
    output logic [7:0]      o_cap_data,
    output logic            o_cap_ok,
    output int              o_cap_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT_NS = 2560;
    logic [7:0] d;
    logic       p;
    initial o_rxd = 1'b1;
    initial o_cap_cnt = 0;
    // frame decode, lsb first, sampled mid bit
    always begin
        @(negedge i_line);
        #(BIT_NS / 2);
        if (i_line === 1'b0) begin
            d = 8'h00;
            for (int i = 0; i < (i_mode[6] ? 7 : 8); i++) begin
                #(BIT_NS);
                d[i] = i_line;
            end
            // no parity bit means nothing to disagree with
            p = i_mode[5] & (^d ^ i_mode[4]);
            if (i_mode[5]) begin
                #(BIT_NS);
                p = p ^ i_line;
            end
            #(BIT_NS);
            o_cap_ok = (i_line === 1'b1) && !p;
            o_cap_data = d;
            o_cap_cnt++;
        end
    end
    // frame send on the same bit time; errors only on request
    task automatic send(input logic [7:0] v, input logic bad_stop, input logic bad_par);
        o_rxd = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < (i_mode[6] ? 7 : 8); i++) begin
            o_rxd = v[i];
            #(BIT_NS);
        end
        if (i_mode[5]) begin
            o_rxd = ^(v & {~i_mode[6], 7'h7f}) ^ i_mode[4] ^ bad_par;
            #(BIT_NS);
        end
        o_rxd = ~bad_stop;
        #(BIT_NS);
        // second stop and idle both sit at mark
        o_rxd = 1'b1;
        #(BIT_NS * 2);
    endtask
endmodule

// File: tb_top.sv
// self-checking bench for the fifo serial unit
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rst = 1, tx_en = 0, rx_en = 0, txclr = 0, rxclr = 0, txwr = 0;
    logic rxrd = 0, strd = 0, stwr = 0, sck = 0, rxd, line, txd, txd_oe, sck_o, sck_oe, prev;
    logic [7:0] mode = 0, cks = 0, div = 8'h01, txdata = 0, rx_data, cap_data, d, e;
    logic [1:0] ttrig = 0;
    logic [6:0] stwd = 0, status;
    logic [4:0] txc, rxc, trg [4] = '{5'h08, 5'h04, 5'h02, 5'h01};
    logic       cap_ok, bs, bp, rts, men = 0, cts = 0;
    int num_errors = 0, tests_run = 0, cnt, k, cap_cnt;
    always #20 mclk = ~mclk;
    // external clock runs free at four master clocks per tick
    always #80 sck = ~sck;
    // released transmit line is pulled up to mark
    assign line = txd_oe ? txd : 1'b1;
    fsu_top fsu_top_inst (.I_MCLK(mclk), .I_RST(rst), .I_MODE(mode), .I_CTRL_CKS(cks),
        .I_TX_ENABLE(tx_en), .I_RX_ENABLE(rx_en), .I_DIVISOR(div), .I_TX_TRIG_SEL(ttrig),
        .I_RX_TRIG_SEL(2'b00), .I_MODEM_EN(men), .I_LOOPBACK(1'b0), .I_TX_FIFO_CLEAR(txclr),
        .I_RX_FIFO_CLEAR(rxclr), .I_TX_WR(txwr), .I_TX_DATA(txdata), .I_RX_RD(rxrd),
        .I_STATUS_RD(strd), .I_STATUS_WR(stwr), .I_STATUS_WDATA(stwd), .I_RXD(rxd),
        .I_CTS_N(cts), .I_SCK(sck), .O_TXD(txd), .O_TXD_OE(txd_oe), .O_SCK(sck_o),
        .O_SCK_OE(sck_oe), .O_RTS_N(rts), .O_RX_DATA(rx_data), .O_STATUS(status),
        .O_TX_COUNT(txc), .O_RX_COUNT(rxc));
    fsu_remote_model remote_inst (.i_line(line), .i_mode(mode), .o_rxd(rxd),
        .o_cap_data(cap_data), .o_cap_ok(cap_ok), .o_cap_cnt(cap_cnt));
    task tick(input int n = 1);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        tests_run++;
        if (got !== ex) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task wrap_up;
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // bounded wait step; running out ends the run
    task step_guard;
        tick();
        cnt++;
        if (cnt > 4000) begin
            num_errors++;
            wrap_up();
        end
    endtask
    // holds the write strobe across the burst, then lets an edge pass
    task push_n(input int n, input logic [7:0] v);
        txwr = 1;
        for (int i = 0; i < n; i++) begin
            txdata = v + 8'(i);
            tick();
        end
        txwr = 0;
        tick();
    endtask
    task clr_flags;
        strd = 1;
        tick();
        strd = 0;
        stwr = 1;
        tick();
        stwr = 0;
        tick(2);
    endtask
    task fifo_clear;
        txclr = 1;
        rxclr = 1;
        tick();
        txclr = 0;
        rxclr = 0;
        tick(2);
    endtask
    initial begin
        tick(16);
        rst = 0;
        tick();
        chk("status", 8'h60, {1'b0, status});
        chk("txcount", 8'h00, {3'b0, txc});
        cks = 8'h01;
        tick(4);
        chk("sckoe", 8'h01, {7'b0, sck_oe});
        cnt = 0;
        prev = sck_o;
        repeat (64) begin
            tick();
            if (sck_o === 1'b1 && prev === 1'b0) cnt++;
            prev = sck_o;
        end
        chk("sckedges", 8'h10, cnt[7:0]);
        for (int s = 0; s < 4; s++) begin
            ttrig = s[1:0];
            fifo_clear();
            push_n(trg[s], 8'h10);
            clr_flags();
            chk("txlow", 8'h00, {7'b0, status[6]});
            fifo_clear();
            chk("txlow", 8'h01, {7'b0, status[6]});
        end
        push_n(17, 8'h20);
        chk("txfull", 8'h10, {3'b0, txc});
        for (int m = 0; m < 8; m++) begin
            tx_en = 0;
            rx_en = 0;
            tick();
            cks = m == 7 ? 8'h02 : 8'h01;
            mode = {1'b0, m[2], m[1], 1'b0, m[0], 3'b000};
            fifo_clear();
            clr_flags();
            tick(64);
            tx_en = 1;
            rx_en = 1;
            tick(2);
            chk("mark", 8'h03, {6'b0, txd_oe, txd});
            d = 8'hc5 + m[7:0];
            e = m[2] ? {1'b0, d[6:0]} : d;
            k = cap_cnt;
            push_n(1, d);
            cnt = 0;
            while (cap_cnt == k) step_guard();
            chk("txdata", e, cap_data);
            chk("txframe", 8'h01, {7'b0, cap_ok});
            if (m == 7) chk("sckoe", 8'h00, {7'b0, sck_oe});
            bs = m == 0;
            bp = m == 2;
            remote_inst.send(~d, bs, bp);
            cnt = 0;
            while (rxc !== 5'h01) step_guard();
            e = m[2] ? {1'b0, ~d[6:0]} : ~d;
            chk("rxdata", e, rx_data);
            chk("rxflags", {4'b0, bs, bp, 2'b11}, {3'b0, status[4:0]});
            chk("txend", 8'h01, {7'b0, status[5]});
            tx_en = 0;
            rx_en = 0;
            tick(2);
            chk("rxkeep", 8'h01, {3'b0, rxc});
            chk("txoe", 8'h00, {7'b0, txd_oe});
            rxrd = 1;
            tick();
            rxrd = 0;
            tick(2);
            chk("rxpop", 8'h00, {3'b0, rxc});
        end
        // clear to send held off, then released, then tx cut mid frame
        men = 1;
        cts = 1;
        fifo_clear();
        tx_en = 1;
        push_n(1, 8'h55);
        tick(200);
        chk("ctshold", 8'h01, {3'b0, txc});
        chk("rts", 8'h00, {7'b0, rts});
        cts = 0;
        tick(100);
        chk("ctsgo", 8'h00, {3'b0, txc});
        tx_en = 0;
        tick(2);
        chk("cutoe", 8'h00, {7'b0, txd_oe});
        wrap_up();
    end
endmodule
